// file: core_regs_pkg.sv
// shared constants, types and helpers for the core status registers
package core_regs_pkg;
   // register indices in the special space; bus byte address is index * 4
   localparam logic [7:0] STACK_IDX   = 8'h81;
   localparam logic [7:0] STATUS_IDX  = 8'hD0;
   localparam logic [7:0] ARITH_IDX   = 8'hE0;
   localparam logic [7:0] EXTRA_IDX   = 8'hF0;
   // values after reset
   localparam logic [7:0] STACK_INIT  = 8'h07;
   localparam logic [7:0] STATUS_INIT = 8'h00;
   localparam logic [7:0] ARITH_INIT  = 8'h00;
   localparam logic [7:0] EXTRA_INIT  = 8'h00;
   // status word field positions
   localparam int CARRY_POS  = 7;
   localparam int NIBBLE_POS = 6;
   localparam int USER0_POS  = 5;
   localparam int BANK_HI    = 4;
   localparam int BANK_LO    = 3;
   localparam int RANGE_POS  = 2;
   localparam int USER1_POS  = 1;
   localparam int PAR_BIT    = 0;
   // bus
   localparam int         AXI_AW     = 12;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   localparam int         RD_LATENCY = 1;

   typedef enum logic [2:0] {
      OP_ADD  = 3'h0,
      OP_ADDC = 3'h1,
      OP_SUBB = 3'h2,
      OP_MUL  = 3'h3,
      OP_DIV  = 3'h4
   } alu_op_t;

   // working register n of a bank sits at eight times the bank plus n
   function automatic logic [7:0] bank_reg_addr(input logic [1:0] bank,
                                                input logic [2:0] idx);
      return {3'h0, bank, idx};
   endfunction

   function automatic logic idx_mapped(input logic [7:0] idx);
      return (idx == STACK_IDX) || (idx == STATUS_IDX) ||
             (idx == ARITH_IDX) || (idx == EXTRA_IDX);
   endfunction

   // bit address hits a byte whose base is a multiple of eight
   function automatic logic bit_hit(input logic [7:0] bit_addr,
                                    input logic [7:0] sfr);
      return bit_addr[7:3] == sfr[7:3];
   endfunction
endpackage

// file: arith_flags_unit.sv
// arithmetic result and flag generation for the accumulator ops
`timescale 1ns/1ps
module arith_flags_unit (
   // operation
   input  wire core_regs_pkg::alu_op_t op,
   input  wire logic [7:0]             a,
   input  wire logic [7:0]             src,
   input  wire logic [7:0]             b,
   input  wire logic                   cy_in,
   // results
   output logic [7:0]                  res_lo,
   output logic [7:0]                  res_hi,
   output logic                        cy,
   output logic                        ac,
   output logic                        ov
);
   logic [8:0]  s9;
   logic [4:0]  n5;
   logic [15:0] p;
   logic        cin;

   always_comb begin
      res_lo = a;
      res_hi = b;
      cy     = 1'b0;
      ac     = 1'b0;
      ov     = 1'b0;
      s9     = 9'h000;
      n5     = 5'h00;
      p      = 16'h0000;
      cin    = (op == core_regs_pkg::OP_ADDC) && cy_in;
      unique case (op)
         core_regs_pkg::OP_ADD, core_regs_pkg::OP_ADDC: begin
            s9     = {1'b0, a} + {1'b0, src} + {8'h00, cin};
            n5     = {1'b0, a[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
            res_lo = s9[7:0];
            cy     = s9[8];
            ac     = n5[4];
            ov     = (a[7] == src[7]) && (s9[7] != a[7]);
         end
         core_regs_pkg::OP_SUBB: begin
            s9     = {1'b0, a} - {1'b0, src} - {8'h00, cy_in};
            n5     = {1'b0, a[3:0]} - {1'b0, src[3:0]} - {4'h0, cy_in};
            res_lo = s9[7:0];
            cy     = s9[8];
            ac     = n5[4];
            ov     = (a[7] != src[7]) && (s9[7] != a[7]);
         end
         core_regs_pkg::OP_MUL: begin
            p      = {8'h00, a} * {8'h00, b};
            res_lo = p[7:0];
            res_hi = p[15:8];
            ov     = |p[15:8];
         end
         core_regs_pkg::OP_DIV: begin
            // quotient of two bytes never exceeds 255, so only zero trips
            if (b == 8'h00) begin
               ov = 1'b1;
            end else begin
               res_lo = a / b;
               res_hi = a % b;
            end
         end
         default: begin
         end
      endcase
   end
endmodule

// file: axil_reg_port.sv
// axi4-lite slave front end for the byte-wide register file
`timescale 1ns/1ps
module axil_reg_port (
   // clock and reset
   input  wire logic                            clock,
   input  wire logic                            rst_n,
   // axi4-lite
   input  wire logic [core_regs_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   input  wire logic [31:0]                     s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   output logic [1:0]                           s_axi_bresp,
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   input  wire logic [core_regs_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   output logic [31:0]                          s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   // register side
   output logic                                 reg_wr_en,
   output logic [7:0]                           reg_wr_idx,
   output logic [7:0]                           reg_wr_data,
   output logic [7:0]                           reg_rd_idx,
   input  wire logic [7:0]                      reg_rd_data
);
   typedef enum logic [3:0] {
      W_IDLE = 4'h1,
      W_ADDR = 4'h2,
      W_DATA = 4'h4,
      W_RESP = 4'h8
   } wr_state_t;

   wr_state_t                        wst_r;
   logic [core_regs_pkg::AXI_AW-1:0] aw_r;
   logic [31:0]                      wd_r;
   logic [3:0]                       ws_r;
   logic [core_regs_pkg::AXI_AW-1:0] use_addr;
   logic [31:0]                      use_data;
   logic [3:0]                       use_strb;
   logic                             commit;
   logic                             wr_ok;
   logic                             rd_ok;
   logic                             rvalid_r;

   function automatic logic addr_ok(
      input logic [core_regs_pkg::AXI_AW-1:0] a);
      return (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
             core_regs_pkg::idx_mapped(a[9:2]);
   endfunction

   assign s_axi_awready = (wst_r == W_IDLE) || (wst_r == W_DATA);
   assign s_axi_wready  = (wst_r == W_IDLE) || (wst_r == W_ADDR);
   assign s_axi_bvalid  = (wst_r == W_RESP);
   assign use_addr      = (wst_r == W_ADDR) ? aw_r : s_axi_awaddr;
   assign use_data      = (wst_r == W_DATA) ? wd_r : s_axi_wdata;
   assign use_strb      = (wst_r == W_DATA) ? ws_r : s_axi_wstrb;
   assign commit = ((wst_r == W_IDLE) && s_axi_awvalid && s_axi_wvalid) ||
                   ((wst_r == W_ADDR) && s_axi_wvalid) ||
                   ((wst_r == W_DATA) && s_axi_awvalid);
   assign wr_ok       = addr_ok(use_addr);
   // only byte lane 0 carries data; upper lanes are ignored
   assign reg_wr_en   = commit && wr_ok && use_strb[0];
   assign reg_wr_idx  = use_addr[9:2];
   assign reg_wr_data = use_data[7:0];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wst_r       <= W_IDLE;
         aw_r        <= '0;
         wd_r        <= 32'h0000_0000;
         ws_r        <= 4'h0;
         s_axi_bresp <= core_regs_pkg::AXI_OKAY;
      end else begin
         unique case (wst_r)
            W_IDLE: begin
               aw_r <= s_axi_awaddr;
               wd_r <= s_axi_wdata;
               ws_r <= s_axi_wstrb;
               if (commit) begin
                  wst_r <= W_RESP;
               end else if (s_axi_awvalid) begin
                  wst_r <= W_ADDR;
               end else if (s_axi_wvalid) begin
                  wst_r <= W_DATA;
               end
            end
            W_ADDR, W_DATA: begin
               if (commit) begin
                  wst_r <= W_RESP;
               end
            end
            W_RESP: begin
               if (s_axi_bready) begin
                  wst_r <= W_IDLE;
               end
            end
         endcase
         if (commit) begin
            s_axi_bresp <= wr_ok ? core_regs_pkg::AXI_OKAY
                                 : core_regs_pkg::AXI_SLVERR;
         end
      end
   end

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign reg_rd_idx    = s_axi_araddr[9:2];
   assign rd_ok         = addr_ok(s_axi_araddr);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r    <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= core_regs_pkg::AXI_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r    <= 1'b1;
         s_axi_rdata <= rd_ok ? {24'h00_0000, reg_rd_data} : 32'h0000_0000;
         s_axi_rresp <= rd_ok ? core_regs_pkg::AXI_OKAY
                              : core_regs_pkg::AXI_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r    <= 1'b0;
      end
   end
endmodule

// file: core_status_and_operand_regs.sv
// stack pointer, accumulators and status word of the core
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module core_status_and_operand_regs (
   // clock and reset
   input  wire logic                             clock,
   input  wire logic                             rst_n,
   // axi4-lite register port
   input  wire logic [core_regs_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire logic [31:0]                      s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   output logic [1:0]                            s_axi_bresp,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   input  wire logic [core_regs_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   output logic [31:0]                           s_axi_rdata,
   output logic [1:0]                            s_axi_rresp,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   // datapath byte and bit access
   input  wire logic                             dp_wr_en,
   input  wire logic [7:0]                       dp_wr_addr,
   input  wire logic [7:0]                       dp_wr_data,
   input  wire logic                             dp_bit_wr_en,
   input  wire logic [7:0]                       dp_bit_addr,
   input  wire logic                             dp_bit_val,
   input  wire logic                             dp_rd_en,
   input  wire logic                             dp_rd_bit,
   input  wire logic [7:0]                       dp_rd_addr,
   output logic [7:0]                            dp_rd_data,
   // stack
   input  wire logic                             push_req,
   input  wire logic                             pop_req,
   output logic [7:0]                            push_addr,
   // arithmetic
   input  wire logic                             alu_req,
   input  wire core_regs_pkg::alu_op_t           alu_op,
   input  wire logic [7:0]                       alu_operand,
   // working register mapping
   input  wire logic [2:0]                       reg_idx,
   output logic [7:0]                            reg_addr,
   // register contents
   output logic [7:0]                            stack_top_pointer,
   output logic [7:0]                            main_arith_reg,
   output logic [7:0]                            extra_operand_reg,
   output logic [7:0]                            core_status_word
);
   logic [7:0] sp_r;
   logic [7:0] sp_nxt;
   logic [7:0] acc_r;
   logic [7:0] acc_nxt;
   logic [7:0] b_r;
   logic [7:0] b_nxt;
   logic [7:1] psw_r;
   logic [7:1] psw_nxt;
   logic [7:0] psw_sw;
   logic [7:0] psw_view;
   logic       bus_wr_en;
   logic [7:0] bus_wr_idx;
   logic [7:0] bus_wr_data;
   logic [7:0] bus_rd_idx;
   logic [7:0] bus_rd_data;
   logic [7:0] alu_lo;
   logic [7:0] alu_hi;
   logic       alu_cy;
   logic       alu_ac;
   logic       alu_ov;
   logic [7:0] rd_byte;
   logic [8:0] add_ref;

   axil_reg_port u_bus (
      .clock         (clock),
      .rst_n         (rst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .reg_wr_en     (bus_wr_en),
      .reg_wr_idx    (bus_wr_idx),
      .reg_wr_data   (bus_wr_data),
      .reg_rd_idx    (bus_rd_idx),
      .reg_rd_data   (bus_rd_data)
   );

   arith_flags_unit u_alu (
      .op     (alu_op),
      .a      (acc_r),
      .src    (alu_operand),
      .b      (b_r),
      .cy_in  (psw_r[core_regs_pkg::CARRY_POS]),
      .res_lo (alu_lo),
      .res_hi (alu_hi),
      .cy     (alu_cy),
      .ac     (alu_ac),
      .ov     (alu_ov)
   );

   // parity is never stored, so it cannot lag the accumulator
   assign psw_view = {psw_r, ^acc_r};

   function automatic logic [7:0] read_sfr(input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         core_regs_pkg::STACK_IDX:  v = sp_r;
         core_regs_pkg::STATUS_IDX: v = psw_view;
         core_regs_pkg::ARITH_IDX:  v = acc_r;
         core_regs_pkg::EXTRA_IDX:  v = b_r;
         default:                v = 8'h00;
      endcase
      return v;
   endfunction

   // software update: datapath wins over the bus, bit write over byte
   function automatic logic [7:0] sw_next(input logic [7:0] cur,
                                          input logic [7:0] sfr,
                                          input logic       bit_able);
      logic [7:0] v;
      v = cur;
      if (bus_wr_en && (bus_wr_idx == sfr)) begin
         v = bus_wr_data;
      end
      if (dp_wr_en && (dp_wr_addr == sfr)) begin
         v = dp_wr_data;
      end
      if (bit_able && dp_bit_wr_en &&
          core_regs_pkg::bit_hit(dp_bit_addr, sfr)) begin
         v[dp_bit_addr[2:0]] = dp_bit_val;
      end
      return v;
   endfunction

   assign bus_rd_data = read_sfr(bus_rd_idx);
   assign rd_byte     = read_sfr({dp_rd_addr[7:3], 3'h0});

   // stack pointer: push before pop, both before software writes
   always_comb begin
      if (push_req) begin
         sp_nxt = sp_r + 8'h01;
      end else if (pop_req) begin
         sp_nxt = sp_r - 8'h01;
      end else begin
         sp_nxt = sw_next(sp_r, core_regs_pkg::STACK_IDX, 1'b0);
      end
   end

   // caller stores the byte at this address in the push cycle
   assign push_addr = sp_r + 8'h01;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= core_regs_pkg::STACK_INIT;
      end else begin
         sp_r <= sp_nxt;
      end
   end

   // accumulators: an arithmetic op outranks any write in the same cycle
   always_comb begin
      if (alu_req) begin
         acc_nxt = alu_lo;
         b_nxt   = alu_hi;
      end else begin
         acc_nxt = sw_next(acc_r, core_regs_pkg::ARITH_IDX, 1'b1);
         b_nxt   = sw_next(b_r, core_regs_pkg::EXTRA_IDX, 1'b1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= core_regs_pkg::ARITH_INIT;
         b_r   <= core_regs_pkg::EXTRA_INIT;
      end else begin
         acc_r <= acc_nxt;
         b_r   <= b_nxt;
      end
   end

   // status word: hardware touches only the arithmetic flags
   always_comb begin
      psw_sw  = sw_next({psw_r, 1'b0},
                        core_regs_pkg::STATUS_IDX, 1'b1);
      psw_nxt = psw_sw[7:1];
      if (alu_req) begin
         psw_nxt[core_regs_pkg::CARRY_POS]  = alu_cy;
         psw_nxt[core_regs_pkg::NIBBLE_POS] = alu_ac;
         psw_nxt[core_regs_pkg::RANGE_POS]  = alu_ov;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         psw_r <= core_regs_pkg::STATUS_INIT[7:1];
      end else begin
         psw_r <= psw_nxt;
      end
   end

   // datapath read data, one cycle after the request
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dp_rd_data <= 8'h00;
      end else if (dp_rd_en) begin
         if (dp_rd_bit) begin
            dp_rd_data <= {7'h00, rd_byte[dp_rd_addr[2:0]]};
         end else begin
            dp_rd_data <= read_sfr(dp_rd_addr);
         end
      end
   end

   assign reg_addr = core_regs_pkg::bank_reg_addr(
                        psw_r[core_regs_pkg::BANK_HI:core_regs_pkg::BANK_LO],
                        reg_idx);

   assign stack_top_pointer = sp_r;
   assign main_arith_reg    = acc_r;
   assign extra_operand_reg = b_r;
   assign core_status_word  = psw_view;

   // reference sum for the carry check
   assign add_ref = {1'b0, acc_r} + {1'b0, alu_operand};

   a_sp_after_reset: assert property (@(posedge clock)
      $rose(rst_n) |-> (sp_r == 8'h07))
      else $error("stack pointer not 0x07 after reset");

   a_push_increments: assert property (@(posedge clock)
      disable iff (!rst_n)
      push_req |=> (sp_r == $past(sp_r) + 8'h01))
      else $error("push did not increment stack pointer");

   a_push_target: assert property (@(posedge clock)
      disable iff (!rst_n)
      push_req |-> ##1 (sp_r == $past(push_addr)))
      else $error("pointer does not hold pushed location");

   a_parity_follows: assert property (@(posedge clock)
      disable iff (!rst_n)
      core_status_word[0] == ^main_arith_reg)
      else $error("parity differs from accumulator");

   a_user_flags_hw: assert property (@(posedge clock)
      disable iff (!rst_n)
      (alu_req && !dp_wr_en && !dp_bit_wr_en && !bus_wr_en) |=>
         $stable(psw_r[core_regs_pkg::USER0_POS]) &&
         $stable(psw_r[core_regs_pkg::USER1_POS]))
      else $error("user flag changed by hardware");

   a_add_carry: assert property (@(posedge clock)
      disable iff (!rst_n)
      (alu_req && (alu_op == core_regs_pkg::OP_ADD)) |=>
         (core_status_word[7] == $past(add_ref[8])) &&
         (main_arith_reg == $past(add_ref[7:0])))
      else $error("add carry or sum wrong");

   a_mul_overflow: assert property (@(posedge clock)
      disable iff (!rst_n)
      (alu_req && (alu_op == core_regs_pkg::OP_MUL)) |=>
         (core_status_word[2] == (extra_operand_reg != 8'h00)) &&
         (core_status_word[7] == 1'b0))
      else $error("multiply overflow flag wrong");

   a_div_zero_ov: assert property (@(posedge clock)
      disable iff (!rst_n)
      (alu_req && (alu_op == core_regs_pkg::OP_DIV) && (b_r == 8'h00)) |=>
         core_status_word[2] && $stable(main_arith_reg))
      else $error("divide by zero not flagged");

   a_div_ov_clear: assert property (@(posedge clock)
      disable iff (!rst_n)
      (alu_req && (alu_op == core_regs_pkg::OP_DIV) && (b_r != 8'h00)) |=>
         !core_status_word[2])
      else $error("overflow not cleared by good divide");

   a_add_signed_ov: assert property (@(posedge clock)
      disable iff (!rst_n)
      (alu_req && (alu_op == core_regs_pkg::OP_ADD) &&
       (acc_r[7] == alu_operand[7]) && (add_ref[7] != acc_r[7])) |=>
         core_status_word[2])
      else $error("signed overflow not flagged");

   a_bank_window: assert property (@(posedge clock)
      disable iff (!rst_n)
      (reg_addr[7:5] == 3'h0) && (reg_addr[2:0] == reg_idx) &&
      (reg_addr[4:3] == core_status_word[4:3]))
      else $error("working register address wrong");
endmodule

// file: core_status_and_operand_regs_test.sv
// self-checking bench for the core status and operand registers
`timescale 1ns/1ps
module core_status_and_operand_regs_test;
   logic        clock = 0, rst_n = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, alu_req = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        dp_wr_en = 0, dp_bit_wr_en = 0, dp_bit_val = 0;
   logic        dp_rd_en = 0, dp_rd_bit = 0, push_req = 0, pop_req = 0;
   logic [7:0]  dp_wr_addr = 0, dp_wr_data = 0, dp_bit_addr = 0;
   logic [7:0]  dp_rd_addr = 0, alu_operand = 0, dp_rd_data, push_addr;
   logic [7:0]  reg_addr, stack_top_pointer, main_arith_reg;
   logic [7:0]  extra_operand_reg, core_status_word;
   logic [2:0]  reg_idx = 0;
   logic [55:0] rw;
   int          n_errors = 0, cmp_count = 0, cyc = 0;
   core_regs_pkg::alu_op_t alu_op = core_regs_pkg::OP_ADD;
   // op, carry in, arith, operand, extra, then expected arith, extra, status
   logic [55:0] rows [6] = '{56'h00_7F_01_5A_80_5A_67,
      56'h11_FF_00_5A_00_5A_E2, 56'h20_80_01_5A_7F_5A_67,
      56'h30_10_00_10_00_01_26, 56'h40_07_00_00_07_00_27,
      56'h40_07_00_02_03_01_22};
   logic [19:0] regs [4] = '{20'h204_07, 20'h340_00, 20'h380_00,
      20'h3C0_00};
   core_status_and_operand_regs dut (.*);
   always #4 clock = ~clock;
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic dpw(logic [7:0] a, logic [7:0] v);
      @(posedge clock);
      dp_wr_en <= 1;
      dp_wr_addr <= a;
      dp_wr_data <= v;
      @(posedge clock);
      dp_wr_en <= 0;
   endtask
   // valids held until ready seen high at the edge
   task automatic axw(logic [11:0] a, logic [7:0] v);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do @(negedge clock); while (!(s_axi_awready && s_axi_wready));
      @(posedge clock);
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      do @(negedge clock); while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge clock);
      s_axi_bready <= 0;
   endtask
   task automatic axr(logic [11:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(negedge clock); while (!s_axi_arready);
      @(posedge clock);
      s_axi_arvalid <= 0;
      do @(negedge clock); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      s_axi_rready <= 0;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1;
      foreach (rows[i]) begin
         rw = rows[i];
         dpw(core_regs_pkg::ARITH_IDX, rw[47:40]);
         dpw(core_regs_pkg::EXTRA_IDX, rw[31:24]);
         dpw(core_regs_pkg::STATUS_IDX, {rw[48], 7'h22});
         alu_op <= core_regs_pkg::alu_op_t'(rw[54:52]);
         alu_operand <= rw[39:32];
         alu_req <= 1;
         @(posedge clock);
         alu_req <= 0;
         @(negedge clock);
         chk("arith", main_arith_reg, rw[23:16]);
         chk("extra", extra_operand_reg, rw[15:8]);
         chk("status", core_status_word, rw[7:0]);
      end
      // second reset in mid-run, after every register but the stack pointer was disturbed
      rst_n <= 0;
      repeat (5) @(posedge clock);
      rst_n <= 1;
      foreach (regs[i]) begin
         axr(regs[i][19:8]);
         chk("reset read", d, {24'h0, regs[i][7:0]});
      end
      @(posedge clock);
      push_req <= 1;
      @(negedge clock);
      chk("push addr", push_addr, 8'h08);
      @(posedge clock);
      push_req <= 0;
      @(negedge clock);
      chk("stack", stack_top_pointer, 8'h08);
      @(posedge clock);
      dp_bit_wr_en <= 1;
      dp_bit_addr <= 8'hD0;
      dp_bit_val <= 1;
      @(posedge clock);
      dp_bit_wr_en <= 0;
      axw(12'h340, 8'h19);
      reg_idx <= 3'h5;
      @(negedge clock);
      chk("status", core_status_word, 8'h18);
      chk("bank addr", reg_addr, 8'h1D);
      axw(12'h380, 8'h01);
      axr(12'h340);
      chk("parity", d, 32'h19);
      axr(12'h004);
      chk("rresp", r, core_regs_pkg::AXI_SLVERR);
      axw(12'h008, 8'h55);
      chk("bresp", r, core_regs_pkg::AXI_SLVERR);
      @(posedge clock);
      pop_req <= 1;
      dp_rd_en <= 1;
      dp_rd_addr <= 8'hE0;
      @(posedge clock);
      pop_req <= 0;
      dp_rd_bit <= 1;
      dp_rd_addr <= 8'hD2;
      @(negedge clock);
      chk("pop", stack_top_pointer, 8'h07);
      chk("byte read", dp_rd_data, 8'h01);
      @(posedge clock);
      dp_rd_en <= 0;
      @(negedge clock);
      chk("bit read", dp_rd_data, 8'h00);
      final_report();
   end
endmodule
